// file: common/charge_bank_defs.svh
// constants for the charge-monitor register bank: register addresses,
// field positions, reset values and timing figures.
// assumes the includer compiles it once per unit; guarded against repeats.
`ifndef CHARGE_BANK_DEFS_SVH
`define CHARGE_BANK_DEFS_SVH

`define ADDR_TEMP_FUEL 7'h02
`define ADDR_NOM_HIGH 7'h03
`define ADDR_PACK_ID 7'h04
`define ADDR_LEARNED_REF 7'h05
`define ADDR_SEC_FLAGS 7'h06
`define ADDR_PULLDOWN 7'h07
`define ADDR_PULLUP 7'h08
`define ADDR_CPI_COUNT 7'h09
`define ADDR_FILTER 7'h0a
`define ADDR_NOM_LOW 7'h17
`define ADDR_SOFT_RESET 7'h39

`define CMD_WRITE_BIT 7
`define SOFT_RESET_IDLE 8'h00
`define SOFT_RESET_FIRE 8'h80

// temperature band codes
`define BAND_MINUS_20 4'h1
`define BAND_ZERO 4'h3
`define BAND_ABOVE_ZERO 4'h4
`define BAND_ABOVE_TEN 4'h5
`define BAND_MAX 4'hc

`define CPI_STALE_LEVEL 8'h40
`define CPI_SAT_LEVEL 8'hff
`define NOM_MAX 16'hffff
`define NOM_ZERO 16'h0000

// 0.94 of the reference expressed as nom*25 < ref*256*94/4
`define NEAR_FULL_NUM 24'h000019
`define NEAR_FULL_DEN 24'h001780

`define FILTER_RESET 8'h00
`define OVERLOAD_HOLD_MS 500
`define CLK_HZ 40000000

`endif

// file: common/charge_bank_pkg.sv
// types shared by the charge-monitor register bank.
// assumes charge_bank_defs.svh supplies the numeric constants.
package charge_bank_pkg;

    typedef enum logic [1:0] {
        scale_full,
        scale_three_quarter,
        scale_half
    } scale_band_e;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] nom_count_t;

endpackage : charge_bank_pkg

// file: rtl/battery_charge_register_bank.sv
// register bank of a battery charge monitor: fuel gauge, nominal count,
// learned full reference, flags, pin maps, stale counter and soft reset.
// assumes the serial link front end delivers whole command/data bytes and
// the analog front end delivers synchronous level and pulse indications.
//
// Overview of operation
// - register 02h holds temperature band and fuel
// - band code 0 to 12 in 10 degree steps
// - fuel in sixteenths from count and reference
// - fuel scaled 0.75 below zero, 0.5 below -20
// - ten degree hysteresis leaving the 0.75 band
// - count high byte writable, low byte read-only
// - first empty warning clears whole nominal count
// - pack id byte kept, no effect on behaviour
// - learned reference writable, loaded from programmed count
// - learn only on qualified full-to-empty discharge
// - fast charge flag set on charge, rate clears
// - discharge rate code tracks -150mV threshold
// - overload flag; sampling resumes 0.5s later
// - pull-down map per led output, top unused
// - pull-up map per led output, top unused
// - stale counter counts charges below 0.94 reference, plus one per stay above 0.94
// - stale counter saturates, flag at 64, learning clears
// - filter register sets valid charge/discharge thresholds
// - writing 00h then 80h to 39h resets
// - reset loads reference and count, clears stale counter, sets stale and swap flags
// - pin six low or floating clears count
// - command byte: bit 7 write, address below
`timescale 1ns/10ps
`include "charge_bank_defs.svh"

module battery_charge_register_bank #(
    parameter int unsigned OVERLOAD_HOLD_CYCLES =
        (`OVERLOAD_HOLD_MS * (`CLK_HZ / 1000)),
    parameter int unsigned HOLD_W = 25
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire charge_bank_pkg::byte_t command_byte_in,
    input wire charge_bank_pkg::byte_t write_data_in,
    input wire logic [3:0] temp_band_code_in,
    input wire logic charge_count_up_in,
    input wire logic discharge_count_down_in,
    input wire logic valid_charge_in,
    input wire logic charge_rate_low_in,
    input wire logic first_empty_warning_in,
    input wire logic sense_below_150_in,
    input wire logic sense_below_250_in,
    input wire logic self_discharge_over_in,
    input wire logic use_programmed_ref_in,
    input wire charge_bank_pkg::byte_t programmed_full_count_in,
    input wire logic program_pin_six_in,
    input wire logic [5:0] led_pulldown_in,
    input wire logic [5:0] led_pullup_in,
    output charge_bank_pkg::byte_t read_data_out,
    output logic read_valid_out,
    output charge_bank_pkg::byte_t charge_threshold_filter_out,
    output logic fast_charge_flag_out,
    output logic overload_flag_out,
    output logic empty_sampling_enable_out,
    output logic stale_full_ref_flag_out,
    output logic discharge_qualified_flag_out,
    output logic pack_swapped_flag_out
);
    import charge_bank_pkg::*;

    // fuel code in sixteenths: largest k with scaled*16 >= k*ref*256
    function automatic logic [3:0] gauge_of(input logic [15:0] scaled,
                                            input byte_t full_ref);
        logic [23:0] lhs;
        logic [23:0] step;
        logic [3:0] res;
        lhs = {4'h0, scaled, 4'h0};
        step = {8'h00, full_ref, 8'h00};
        res = 4'h0;
        for (int k = 1; k <= 15; k++) begin
            if (lhs >= step * 24'(k)) begin
                res = 4'(k);
            end
        end
        return res;
    endfunction : gauge_of

    function automatic logic is_write(input byte_t cmd);
        return cmd[`CMD_WRITE_BIT];
    endfunction : is_write

    byte_t temp_and_fuel_level;
    nom_count_t nominal_charge_count;
    byte_t pack_type_id;
    byte_t learned_full_reference;
    byte_t secondary_flags;
    byte_t pin_pulldown_map;
    byte_t pin_pullup_map;
    byte_t charge_without_update_count;
    byte_t charge_threshold_filter;
    byte_t soft_reset_trigger;
    scale_band_e scale_band;
    logic init_pending;
    logic soft_reset_fire;
    logic near_full_latched;
    logic empty_seen;
    logic [15:0] learned_discharge;
    logic [HOLD_W-1:0] overload_hold;

    logic [6:0] cmd_addr;
    logic wr_strobe;
    logic rd_strobe;
    logic do_init;
    byte_t active_ref;
    logic [15:0] scaled_count;
    logic cold_temp;
    logic below_near_full;
    logic learn_now;
    logic [7:0] next_cpi;

    assign cmd_addr = command_byte_in[6:0];
    assign wr_strobe = cmd_valid_in && is_write(command_byte_in);
    assign rd_strobe = cmd_valid_in && !is_write(command_byte_in);
    assign do_init = init_pending || soft_reset_fire;
    assign cold_temp = temp_band_code_in < `BAND_ABOVE_ZERO;
    assign active_ref = use_programmed_ref_in ? programmed_full_count_in :
                        learned_full_reference;

    // async reset can only load constants, so the full-count load is run
    // one clock after release via init_pending
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            init_pending <= 1'b1;
        end else begin
            init_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            soft_reset_trigger <= `SOFT_RESET_IDLE;
            soft_reset_fire <= 1'b0;
        end else begin
            soft_reset_fire <= 1'b0;
            if (soft_reset_fire) begin
                soft_reset_trigger <= `SOFT_RESET_IDLE;
            end else if (wr_strobe && cmd_addr == `ADDR_SOFT_RESET) begin
                soft_reset_trigger <= write_data_in;
                // only the 00h to 80h transition fires
                if (soft_reset_trigger == `SOFT_RESET_IDLE &&
                    write_data_in == `SOFT_RESET_FIRE) begin
                    soft_reset_fire <= 1'b1;
                end
            end
        end
    end

    // cold scaling band; leaving 0.75 needs the band above +10 degrees
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scale_band <= scale_full;
        end else begin
            case (scale_band)
                scale_full: begin
                    if (temp_band_code_in <= `BAND_MINUS_20) begin
                        scale_band <= scale_half;
                    end else if (temp_band_code_in <= `BAND_ZERO) begin
                        scale_band <= scale_three_quarter;
                    end
                end
                scale_three_quarter: begin
                    if (temp_band_code_in <= `BAND_MINUS_20) begin
                        scale_band <= scale_half;
                    end else if (temp_band_code_in >= `BAND_ABOVE_TEN) begin
                        scale_band <= scale_full;
                    end
                end
                scale_half: begin
                    if (temp_band_code_in > `BAND_MINUS_20) begin
                        scale_band <= scale_three_quarter;
                    end
                end
                default: begin
                    scale_band <= scale_full;
                end
            endcase
        end
    end

    always_comb begin
        case (scale_band)
            scale_three_quarter: begin
                scaled_count = nominal_charge_count -
                               (nominal_charge_count >> 2);
            end
            scale_half: begin
                scaled_count = nominal_charge_count >> 1;
            end
            default: begin
                scaled_count = nominal_charge_count;
            end
        endcase
    end

    // band codes above twelve are never produced; clamp to be safe
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            temp_and_fuel_level <= 8'h00;
        end else begin
            temp_and_fuel_level[7:4] <= (temp_band_code_in > `BAND_MAX) ?
                `BAND_MAX : temp_band_code_in;
            temp_and_fuel_level[3:0] <= gauge_of(scaled_count,
                                                 active_ref);
        end
    end

    // empty warning beats host write, which beats counting
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nominal_charge_count <= `NOM_ZERO;
        end else if (do_init) begin
            if (program_pin_six_in) begin
                nominal_charge_count <= {programmed_full_count_in,
                                         8'h00};
            end else begin
                nominal_charge_count <= `NOM_ZERO;
            end
        end else if (first_empty_warning_in) begin
            nominal_charge_count <= `NOM_ZERO;
        end else if (wr_strobe && cmd_addr == `ADDR_NOM_HIGH) begin
            nominal_charge_count[15:8] <= write_data_in;
        end else if (charge_count_up_in && !discharge_count_down_in) begin
            if (nominal_charge_count != `NOM_MAX) begin
                nominal_charge_count <= nominal_charge_count + 16'h0001;
            end
        end else if (discharge_count_down_in && !charge_count_up_in) begin
            if (nominal_charge_count != `NOM_ZERO) begin
                nominal_charge_count <= nominal_charge_count - 16'h0001;
            end
        end
    end

    // pack id survives soft reset; only power loss clears it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pack_type_id <= 8'h00;
        end else if (wr_strobe && cmd_addr == `ADDR_PACK_ID) begin
            pack_type_id <= write_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            charge_threshold_filter <= `FILTER_RESET;
        end else if (wr_strobe && cmd_addr == `ADDR_FILTER) begin
            charge_threshold_filter <= write_data_in;
        end
    end

    // learning qualification: discharge starting at count == reference
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            discharge_qualified_flag_out <= 1'b0;
            learned_discharge <= 16'h0000;
        end else if (do_init || learn_now) begin
            discharge_qualified_flag_out <= 1'b0;
            learned_discharge <= 16'h0000;
        end else if (valid_charge_in || self_discharge_over_in ||
                     (first_empty_warning_in && cold_temp)) begin
            discharge_qualified_flag_out <= 1'b0;
            learned_discharge <= 16'h0000;
        end else if (discharge_count_down_in) begin
            if (nominal_charge_count ==
                {learned_full_reference, 8'h00}) begin
                discharge_qualified_flag_out <= 1'b1;
                learned_discharge <= 16'h0001;
            end else if (discharge_qualified_flag_out &&
                         learned_discharge != `NOM_MAX) begin
                learned_discharge <= learned_discharge + 16'h0001;
            end
        end
    end

    assign learn_now = discharge_qualified_flag_out && first_empty_warning_in &&
                       !cold_temp && !valid_charge_in &&
                       !self_discharge_over_in;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            learned_full_reference <= 8'h00;
        end else if (do_init) begin
            learned_full_reference <= programmed_full_count_in;
        end else if (learn_now) begin
            learned_full_reference <= learned_discharge[15:8];
        end else if (wr_strobe && cmd_addr == `ADDR_LEARNED_REF) begin
            learned_full_reference <= write_data_in;
        end
    end

    // nom*25 < ref*6016 is the 0.94 comparison without a divider
    assign below_near_full =
        ({8'h00, nominal_charge_count} * `NEAR_FULL_NUM) <
        ({16'h0000, learned_full_reference} * `NEAR_FULL_DEN);

    always_comb begin
        next_cpi = charge_without_update_count;
        if (valid_charge_in && charge_without_update_count != `CPI_SAT_LEVEL &&
            (below_near_full || !near_full_latched)) begin
            next_cpi = charge_without_update_count + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            charge_without_update_count <= 8'h00;
            near_full_latched <= 1'b0;
            stale_full_ref_flag_out <= 1'b0;
        end else if (do_init) begin
            charge_without_update_count <= 8'h00;
            near_full_latched <= 1'b0;
            stale_full_ref_flag_out <= 1'b1;
        end else if (learn_now) begin
            charge_without_update_count <= 8'h00;
            near_full_latched <= 1'b0;
            stale_full_ref_flag_out <= 1'b0;
        end else begin
            charge_without_update_count <= next_cpi;
            // one count per stay above 0.94; released by dropping below
            if (below_near_full) begin
                near_full_latched <= 1'b0;
            end else if (valid_charge_in) begin
                near_full_latched <= 1'b1;
            end
            if (next_cpi == `CPI_STALE_LEVEL) begin
                stale_full_ref_flag_out <= 1'b1;
            end
        end
    end

    // swap flag: set by reset, cleared by a charge to full or after empty
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pack_swapped_flag_out <= 1'b1;
            empty_seen <= 1'b0;
        end else if (do_init) begin
            pack_swapped_flag_out <= 1'b1;
            empty_seen <= 1'b0;
        end else begin
            if (first_empty_warning_in) begin
                empty_seen <= 1'b1;
            end else if (valid_charge_in) begin
                empty_seen <= 1'b0;
            end
            if (valid_charge_in && (empty_seen || (charge_count_up_in &&
                nominal_charge_count + 16'h0001 ==
                {learned_full_reference, 8'h00}))) begin
                pack_swapped_flag_out <= 1'b0;
            end
        end
    end

    // set wins over clear when a charge begins as the rate drops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fast_charge_flag_out <= 1'b0;
        end else if (valid_charge_in && !fast_charge_flag_out) begin
            fast_charge_flag_out <= 1'b1;
        end else if (charge_rate_low_in) begin
            fast_charge_flag_out <= 1'b0;
        end
    end

    // sampling waits the hold time after the overload ends
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            overload_flag_out <= 1'b0;
            overload_hold <= '0;
            empty_sampling_enable_out <= 1'b1;
        end else begin
            overload_flag_out <= sense_below_250_in;
            if (sense_below_250_in) begin
                overload_hold <= HOLD_W'(OVERLOAD_HOLD_CYCLES);
                empty_sampling_enable_out <= 1'b0;
            end else if (overload_hold != '0) begin
                overload_hold <= overload_hold - HOLD_W'(1);
                empty_sampling_enable_out <= (overload_hold == HOLD_W'(1));
            end else begin
                empty_sampling_enable_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            secondary_flags <= 8'h00;
            pin_pulldown_map <= 8'h00;
            pin_pullup_map <= 8'h00;
            charge_threshold_filter_out <= `FILTER_RESET;
        end else begin
            charge_threshold_filter_out <= charge_threshold_filter;
            secondary_flags <= {fast_charge_flag_out, 2'b00,
                                sense_below_150_in, 3'b000,
                                sense_below_250_in};
            pin_pulldown_map <= {2'b00, led_pulldown_in};
            pin_pullup_map <= {2'b00, led_pullup_in};
        end
    end

    // unmapped and write-only addresses read as zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            read_data_out <= 8'h00;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= rd_strobe;
            if (rd_strobe) begin
                case (cmd_addr)
                    `ADDR_TEMP_FUEL: read_data_out <= temp_and_fuel_level;
                    `ADDR_NOM_HIGH: read_data_out <= nominal_charge_count[15:8];
                    `ADDR_PACK_ID: read_data_out <= pack_type_id;
                    `ADDR_LEARNED_REF: read_data_out <= learned_full_reference;
                    `ADDR_SEC_FLAGS: read_data_out <= secondary_flags;
                    `ADDR_PULLDOWN: read_data_out <= pin_pulldown_map;
                    `ADDR_PULLUP: read_data_out <= pin_pullup_map;
                    `ADDR_CPI_COUNT: read_data_out <= charge_without_update_count;
                    `ADDR_FILTER: read_data_out <= charge_threshold_filter;
                    `ADDR_NOM_LOW: read_data_out <= nominal_charge_count[7:0];
                    default: read_data_out <= 8'h00;
                endcase
            end
        end
    end

endmodule : battery_charge_register_bank

// file: test/charge_bank_props.sv
// concurrent checks on the charge-monitor register bank top-level ports.
// assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module charge_bank_props #(
    parameter int unsigned OVERLOAD_HOLD_CYCLES = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire charge_bank_pkg::byte_t command_byte_in,
    input wire charge_bank_pkg::byte_t write_data_in,
    input wire logic valid_charge_in,
    input wire logic charge_rate_low_in,
    input wire logic sense_below_250_in,
    input wire logic read_valid_out,
    input wire charge_bank_pkg::byte_t charge_threshold_filter_out,
    input wire logic fast_charge_flag_out,
    input wire logic overload_flag_out,
    input wire logic empty_sampling_enable_out,
    input wire logic stale_full_ref_flag_out,
    input wire logic discharge_qualified_flag_out,
    input wire logic pack_swapped_flag_out
);
    import charge_bank_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence rd_cmd_s; cmd_valid_in && !command_byte_in[7]; endsequence
    sequence hold_off_s; (!empty_sampling_enable_out)[*4]; endsequence
    sequence soft_fire_s;
        cmd_valid_in && command_byte_in == 8'hb9 && write_data_in == 8'h80;
    endsequence
    read_answer_a: assert property (rd_cmd_s |=> read_valid_out)
        else $error("read command not answered");
    no_stray_answer_a: assert property (read_valid_out |-> $past(cmd_valid_in && !command_byte_in[7]))
        else $error("answer without a read command");
    overload_follow_a: assert property (overload_flag_out == $past(sense_below_250_in))
        else $error("overload flag does not follow sense");
    sample_stop_a: assert property (overload_flag_out |=> !empty_sampling_enable_out)
        else $error("sampling on during overload");
    sample_resume_a: assert property (($fell(overload_flag_out) && !sense_below_250_in)
        |-> hold_off_s ##[1:16] empty_sampling_enable_out) else $error("sampling hold wrong");
    filter_copy_a: assert property (cmd_valid_in && command_byte_in == 8'h8a
        |-> ##2 charge_threshold_filter_out == $past(write_data_in, 2)) else $error("filter");
    fast_set_a: assert property (valid_charge_in && !fast_charge_flag_out |=> fast_charge_flag_out)
        else $error("fast flag not set by charge");
    fast_clear_a: assert property (charge_rate_low_in && !valid_charge_in |=> !fast_charge_flag_out)
        else $error("fast flag not cleared by low rate");
    soft_reset_a: assert property (soft_fire_s |-> ##[2:4] (stale_full_ref_flag_out &&
        pack_swapped_flag_out && !discharge_qualified_flag_out)) else $error("soft reset flags");
endmodule : charge_bank_props

bind battery_charge_register_bank charge_bank_props #(
    .OVERLOAD_HOLD_CYCLES(OVERLOAD_HOLD_CYCLES)
) u_props (.clk_in, .rst_b_in, .cmd_valid_in, .command_byte_in, .write_data_in,
    .valid_charge_in, .charge_rate_low_in, .sense_below_250_in, .read_valid_out,
    .charge_threshold_filter_out, .fast_charge_flag_out, .overload_flag_out,
    .empty_sampling_enable_out, .stale_full_ref_flag_out, .discharge_qualified_flag_out,
    .pack_swapped_flag_out);

// file: test/host_port.sv
// model of the host processor issuing command bytes to the register bank.
// assumes the serial link is already decoded into whole bytes per access.
`timescale 1ns/10ps
module host_port (
    input wire logic clk_in,
    input wire logic read_valid_in,
    input wire charge_bank_pkg::byte_t read_data_in,
    output logic cmd_valid_out,
    output charge_bank_pkg::byte_t command_byte_out,
    output charge_bank_pkg::byte_t write_data_out
);
    import charge_bank_pkg::*;
    initial begin
        cmd_valid_out = 1'b0;
        command_byte_out = 8'h00;
        write_data_out = 8'h00;
    end
    // callers keep count writes at or below the learned reference
    // and filter values above the sense offset
    task automatic xfer(input logic wr, input logic [6:0] a, input byte_t d, input int gap,
                        output byte_t q);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        command_byte_out <= {wr, a};
        write_data_out <= (a == 7'h39) ? (d & 8'h80) : d; // only the top bit of 39h
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // released lines show the inverse so a stale byte is never reused
        command_byte_out <= ~{wr, a};
        write_data_out <= ~d;
        @(posedge clk_in);
        q = (read_valid_in === 1'b1) ? read_data_in : 8'hee;
    endtask : xfer
endmodule : host_port

// file: test/tb_top.sv
// self-checking bench for the charge-monitor register bank.
// assumes the overload hold is shortened to 8 cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import charge_bank_pkg::*;
    logic clk_in, rst_b_in, up, down, vchg, rate_low, empty, s150, s250, sdo, use_prog, pin6;
    logic cmd_valid, rd_valid, fast, overload_flag, samp, stale, qual, swapped;
    logic [3:0] band;
    logic [5:0] pd, pu;
    byte_t programmed_full_count, q, cmd, wdata, rdata, filt;
    int bad_count, comparisons;
    battery_charge_register_bank #(.OVERLOAD_HOLD_CYCLES(8)) dut (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid), .command_byte_in(cmd),
        .write_data_in(wdata), .temp_band_code_in(band), .charge_count_up_in(up),
        .discharge_count_down_in(down), .valid_charge_in(vchg), .charge_rate_low_in(rate_low),
        .first_empty_warning_in(empty), .sense_below_150_in(s150), .sense_below_250_in(s250),
        .self_discharge_over_in(sdo), .use_programmed_ref_in(use_prog),
        .programmed_full_count_in(programmed_full_count), .program_pin_six_in(pin6), .led_pulldown_in(pd),
        .led_pullup_in(pu), .read_data_out(rdata), .read_valid_out(rd_valid),
        .charge_threshold_filter_out(filt), .fast_charge_flag_out(fast),
        .overload_flag_out(overload_flag), .empty_sampling_enable_out(samp),
        .stale_full_ref_flag_out(stale), .discharge_qualified_flag_out(qual),
        .pack_swapped_flag_out(swapped));
    host_port h (.clk_in(clk_in), .read_valid_in(rd_valid), .read_data_in(rdata),
        .cmd_valid_out(cmd_valid), .command_byte_out(cmd), .write_data_out(wdata));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    task automatic wr(input logic [6:0] a, input byte_t d, input int gap);
        h.xfer(1'b1, a, d, gap, q);
    endtask : wr
    task automatic rd(input logic [6:0] a, input byte_t e);
        h.xfer(1'b0, a, 8'h00, 0, q);
        `CHK(q, e)
    endtask : rd
    task automatic t_regs;
        wr(7'h04, 8'h5a, 0);
        rd(7'h04, 8'h5a);
        wr(7'h04, 8'ha5, 3);
        rd(7'h04, 8'ha5);
        wr(7'h0a, 8'h3c, 0);
        rd(7'h0a, 8'h3c);
        `CHK(filt, 8'h3c)
        rd(7'h07, 8'h09);
        rd(7'h08, 8'h24);
        rd(7'h7f, 8'h00);
        rd(7'h39, 8'h00);
        wr(7'h06, 8'hff, 0);
        rd(7'h06, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_reset_load;
        rd(7'h05, 8'h40);
        rd(7'h03, 8'h40);
        rd(7'h17, 8'h00);
        rd(7'h09, 8'h00);
        rd(7'h02, 8'h4f);
        `CHK({stale, swapped, qual}, 3'b110)
        $display("test reset load done");
    endtask : t_reset_load
    task automatic t_count;
        wr(7'h03, 8'h12, 0);
        up <= 1'b1; cyc(3); up <= 1'b0;
        rd(7'h17, 8'h03);
        wr(7'h03, 8'h11, 0);
        wr(7'h17, 8'h55, 0);
        rd(7'h03, 8'h11);
        rd(7'h17, 8'h03);
        empty <= 1'b1; cyc(1); empty <= 1'b0;
        rd(7'h03, 8'h00);
        rd(7'h17, 8'h00);
        $display("test count done");
    endtask : t_count
    task automatic t_fuel;
        wr(7'h03, 8'h20, 0);
        rd(7'h02, 8'h48);
        band <= 4'h2; cyc(4);
        rd(7'h02, 8'h26);
        band <= 4'h4; cyc(4);
        rd(7'h02, 8'h46);
        band <= 4'h5; cyc(4);
        rd(7'h02, 8'h58);
        band <= 4'h1; cyc(4);
        rd(7'h02, 8'h14);
        $display("test fuel done");
    endtask : t_fuel
    task automatic t_flags;
        @(posedge clk_in); vchg <= 1'b1;
        @(posedge clk_in); vchg <= 1'b0;
        rd(7'h09, 8'h01);
        s150 <= 1'b1;
        rd(7'h06, 8'h90);
        s250 <= 1'b1; cyc(2);
        rd(7'h06, 8'h91);
        `CHK(samp, 1'b0)
        s250 <= 1'b0; s150 <= 1'b0; rate_low <= 1'b1; cyc(20);
        rd(7'h06, 8'h00);
        `CHK(samp, 1'b1)
        $display("test flags done");
    endtask : t_flags
    task automatic t_soft;
        pin6 <= 1'b0; programmed_full_count <= 8'h30;
        wr(7'h39, 8'h80, 0);
        cyc(4);
        rd(7'h05, 8'h30);
        rd(7'h03, 8'h00);
        rd(7'h17, 8'h00);
        rd(7'h09, 8'h00);
        rd(7'h04, 8'ha5);
        `CHK({stale, swapped, qual}, 3'b110)
        $display("test soft reset done");
    endtask : t_soft
    task automatic t_learn;
        band <= 4'h5;
        wr(7'h03, 8'h30, 0);
        down <= 1'b1; cyc(256); down <= 1'b0;
        `CHK(qual, 1'b1)
        empty <= 1'b1; cyc(1); empty <= 1'b0;
        rd(7'h05, 8'h01);
        `CHK({stale, qual}, 2'b00)
        $display("test learn done");
    endtask : t_learn
    task automatic close_out;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        bad_count = 0; comparisons = 0; rst_b_in = 1'b0;
        {up, down, vchg, rate_low, empty, s150, s250, sdo, use_prog} = 9'h000;
        band = 4'h4; pd = 6'b001001; pu = 6'b100100; programmed_full_count = 8'h40; pin6 = 1'b1;
        cyc(8);
        rst_b_in <= 1'b1;
        cyc(2);
        t_regs(); t_reset_load(); t_count(); t_fuel(); t_flags(); t_soft(); t_learn();
        close_out();
    end
    initial begin
        #125000;
        bad_count++;
        close_out();
    end
endmodule : tb_top
